// ### crc_pkg.sv
// Package with constants and carriers for the core reset and clear operations block.
package crc_pkg;
    localparam logic [4:0] STATUS_ADDR = 5'h03;
    localparam logic [4:0] PORT_B_ADDR = 5'h06;
    localparam int TIMEOUT_BIT = 4;
    localparam int POWERDOWN_BIT = 3;
    localparam int Z_BIT = 2;
    localparam int PA_HI = 6;
    localparam int PA_LO = 5;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] STATUS_KEEP_MASK = 8'h07;
    localparam logic [3:0] CALL_OP = 4'h9;
    localparam logic [6:0] ZERO_FILE_OP = 7'h03;
    localparam logic [11:0] ZERO_WORKING_OP = 12'h040;
    localparam logic [11:0] WATCHDOG_KICK_OP = 12'h004;
    localparam logic [3:0] BIT_ZERO_OP = 4'h4;
    localparam logic [3:0] BIT_ONE_OP = 4'h5;
    localparam logic [10:0] RESET_VECTOR = 11'h7FF;
    localparam int STACK_DEPTH = 2;

    typedef enum logic [2:0] {
        RST_NONE, RST_POWER_ON, RST_CLEAR_RUN, RST_CLEAR_WAKE, RST_DOG_RUN, RST_DOG_WAKE
    } crc_cause_type;

    typedef struct packed {
        logic [7:0] out_latch;
        logic [7:0] dir_in;
    } crc_port_type;
endpackage

// ### crc_core.sv
// Core reset cause flags, call, clear instructions and port read-modify-write.
`timescale 1ns/1ps
module crc_core (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic power_on,
    input wire logic master_clear_n,
    input wire logic watchdog_timeout,
    input wire logic sleeping,
    input wire logic [11:0] instr,
    input wire logic instr_valid,
    input wire logic prescaler_to_watchdog,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_dir_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe_n,
    output logic [7:0] status,
    output logic [7:0] working,
    output logic [10:0] program_counter,
    output logic [10:0] stack_top,
    output logic watchdog_clear,
    output logic prescaler_clear,
    output logic instr_busy,
    output logic [4:0] file_wr_addr,
    output logic file_wr_en
);
    logic [7:0] pin_s1_reg, pin_s2_reg;
    logic clr_s1_reg, clr_s2_reg, dog_s1_reg, dog_s2_reg;
    logic [7:0] status_reg, status_next, working_reg, working_next;
    logic [10:0] pcnt_reg, pcnt_next;
    logic [10:0] stack_reg [crc_pkg::STACK_DEPTH];
    logic [10:0] stack_next [crc_pkg::STACK_DEPTH];
    crc_pkg::crc_port_type port_reg, port_next;
    logic busy_reg, busy_next, wdc_reg, wdc_next, psc_reg, psc_next;
    logic [4:0] fwa_reg, fwa_next;
    logic fwe_reg, fwe_next;
    crc_pkg::crc_cause_type cause;
    logic [7:0] rmw_byte;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
            clr_s1_reg <= 1'b1;
            clr_s2_reg <= 1'b1;
            dog_s1_reg <= 1'b0;
            dog_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= port_b_in;
            pin_s2_reg <= pin_s1_reg;
            clr_s1_reg <= master_clear_n;
            clr_s2_reg <= clr_s1_reg;
            dog_s1_reg <= watchdog_timeout;
            dog_s2_reg <= dog_s1_reg;
        end
    end

    // Reset cause decode; low master clear resets the device.
    always_comb begin
        cause = crc_pkg::RST_NONE;
        if (power_on) begin
            cause = crc_pkg::RST_POWER_ON;
        end else if (!clr_s2_reg) begin
            cause = sleeping ? crc_pkg::RST_CLEAR_WAKE : crc_pkg::RST_CLEAR_RUN;
        end else if (dog_s2_reg) begin
            cause = sleeping ? crc_pkg::RST_DOG_WAKE : crc_pkg::RST_DOG_RUN;
        end
    end

    // Read-modify-write byte: input bits take pin level, outputs take latch.
    always_comb begin
        rmw_byte = (pin_s2_reg & port_reg.dir_in)
            | (port_reg.out_latch & ~port_reg.dir_in);
        rmw_byte[instr[7:5]] = (instr[11:8] == crc_pkg::BIT_ONE_OP);
    end

    always_comb begin
        status_next = status_reg;
        working_next = working_reg;
        pcnt_next = pcnt_reg;
        stack_next = stack_reg;
        port_next = port_reg;
        port_next.dir_in = port_dir_in;
        busy_next = 1'b0;
        wdc_next = 1'b0;
        psc_next = 1'b0;
        fwa_next = fwa_reg;
        fwe_next = 1'b0;
        if (cause != crc_pkg::RST_NONE) begin
            pcnt_next = crc_pkg::RESET_VECTOR;
            // Working register and file contents are kept on every reset cause; sys_rst clears the working register.
            status_next = (status_reg & crc_pkg::STATUS_KEEP_MASK);
            unique case (cause)
                crc_pkg::RST_POWER_ON: status_next = crc_pkg::STATUS_POR;
                crc_pkg::RST_CLEAR_RUN: begin
                    status_next[crc_pkg::TIMEOUT_BIT] = status_reg[crc_pkg::TIMEOUT_BIT];
                    status_next[crc_pkg::POWERDOWN_BIT] = status_reg[crc_pkg::POWERDOWN_BIT];
                end
                crc_pkg::RST_CLEAR_WAKE: begin
                    status_next[crc_pkg::TIMEOUT_BIT] = 1'b1;
                    status_next[crc_pkg::POWERDOWN_BIT] = 1'b0;
                end
                crc_pkg::RST_DOG_RUN: begin
                    status_next[crc_pkg::TIMEOUT_BIT] = 1'b0;
                    status_next[crc_pkg::POWERDOWN_BIT] = 1'b1;
                end
                default: begin
                    status_next[crc_pkg::TIMEOUT_BIT] = 1'b0;
                    status_next[crc_pkg::POWERDOWN_BIT] = 1'b0;
                end
            endcase
        end else if (busy_reg) begin
            busy_next = 1'b0;
        end else if (instr_valid) begin
            pcnt_next = pcnt_reg + 11'h001;
            if (instr[11:8] == crc_pkg::CALL_OP) begin
                for (int i = crc_pkg::STACK_DEPTH - 1; i > 0; i--) begin
                    stack_next[i] = stack_reg[i - 1];
                end
                stack_next[0] = pcnt_reg + 11'h001;
                pcnt_next = {status_reg[crc_pkg::PA_HI:crc_pkg::PA_LO], 1'b0,
                    instr[7:0]};
                busy_next = 1'b1;
            end else if (instr[11:5] == crc_pkg::ZERO_FILE_OP) begin
                fwa_next = instr[4:0];
                fwe_next = 1'b1;
                status_next[crc_pkg::Z_BIT] = 1'b1;
                if (instr[4:0] == crc_pkg::STATUS_ADDR) begin
                    status_next = 8'h00;
                    status_next[crc_pkg::Z_BIT] = 1'b1;
                    status_next[crc_pkg::TIMEOUT_BIT] = status_reg[crc_pkg::TIMEOUT_BIT];
                    status_next[crc_pkg::POWERDOWN_BIT] = status_reg[crc_pkg::POWERDOWN_BIT];
                end
                if (instr[4:0] == crc_pkg::PORT_B_ADDR) begin
                    port_next.out_latch = 8'h00;
                end
            end else if (instr == crc_pkg::ZERO_WORKING_OP) begin
                working_next = 8'h00;
                status_next[crc_pkg::Z_BIT] = 1'b1;
            end else if (instr == crc_pkg::WATCHDOG_KICK_OP) begin
                wdc_next = 1'b1;
                psc_next = prescaler_to_watchdog;
                status_next[crc_pkg::TIMEOUT_BIT] = 1'b1;
                status_next[crc_pkg::POWERDOWN_BIT] = 1'b1;
            end else if ((instr[11:8] == crc_pkg::BIT_ZERO_OP
                          || instr[11:8] == crc_pkg::BIT_ONE_OP)
                         && instr[4:0] == crc_pkg::PORT_B_ADDR) begin
                port_next.out_latch = rmw_byte;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_reg <= crc_pkg::STATUS_POR;
            working_reg <= 8'h00;
            pcnt_reg <= crc_pkg::RESET_VECTOR;
            stack_reg <= '{default: 11'h000};
            port_reg <= '{out_latch: 8'h00, dir_in: 8'hFF};
            busy_reg <= 1'b0;
            wdc_reg <= 1'b0;
            psc_reg <= 1'b0;
            fwa_reg <= 5'h00;
            fwe_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            working_reg <= working_next;
            pcnt_reg <= pcnt_next;
            stack_reg <= stack_next;
            port_reg <= port_next;
            busy_reg <= busy_next;
            wdc_reg <= wdc_next;
            psc_reg <= psc_next;
            fwa_reg <= fwa_next;
            fwe_reg <= fwe_next;
        end
    end

    assign status = status_reg;
    assign working = working_reg;
    assign program_counter = pcnt_reg;
    assign stack_top = stack_reg[0];
    assign port_b_out = port_reg.out_latch;
    assign port_b_oe_n = port_reg.dir_in;
    assign watchdog_clear = wdc_reg;
    assign prescaler_clear = psc_reg;
    assign instr_busy = busy_reg;
    assign file_wr_addr = fwa_reg;
    assign file_wr_en = fwe_reg;

    logic quiet;
    assign quiet = !power_on && clr_s2_reg && !dog_s2_reg;

    a_kick_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
        quiet && !busy_reg && instr_valid && instr == crc_pkg::WATCHDOG_KICK_OP
        |=> status_reg[4:3] == 2'b11 && wdc_reg)
        else $error("watchdog clear did not set flags");
    a_kick_presc: assert property (@(posedge sys_clk) disable iff (sys_rst)
        psc_reg |-> wdc_reg && $past(prescaler_to_watchdog))
        else $error("prescaler cleared wrongly");
    a_call_target: assert property (@(posedge sys_clk) disable iff (sys_rst)
        quiet && !busy_reg && instr_valid && instr[11:8] == crc_pkg::CALL_OP
        |=> pcnt_reg == {$past(status_reg[6:5]), 1'b0, $past(instr[7:0])}
            && stack_reg[0] == $past(pcnt_reg) + 11'h001)
        else $error("call target or push wrong");
    a_call_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
        quiet && !busy_reg && instr_valid && instr[11:8] == crc_pkg::CALL_OP
        |=> busy_reg ##1 !busy_reg)
        else $error("call not two cycles");
    a_zero_working: assert property (@(posedge sys_clk) disable iff (sys_rst)
        quiet && !busy_reg && instr_valid && instr == crc_pkg::ZERO_WORKING_OP
        |=> working_reg == 8'h00 && status_reg[2])
        else $error("clear working failed");
    a_zero_file: assert property (@(posedge sys_clk) disable iff (sys_rst)
        quiet && !busy_reg && instr_valid && instr[11:5] == crc_pkg::ZERO_FILE_OP
        |=> file_wr_en && file_wr_addr == $past(instr[4:0]) && status_reg[2])
        else $error("clear file failed");
    a_por_status: assert property (@(posedge sys_clk) disable iff (sys_rst)
        power_on |=> status_reg[7:3] == 5'b00011)
        else $error("power on status wrong");
    a_watchdog_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !power_on && clr_s2_reg && dog_s2_reg && sleeping
        |=> status_reg[4:3] == 2'b00 && pcnt_reg == crc_pkg::RESET_VECTOR)
        else $error("watchdog wake flags wrong");
    a_clear_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !power_on && !clr_s2_reg && !sleeping |=> $stable(status_reg[4:3]))
        else $error("master clear changed flags");
    a_rmw_input: assert property (@(posedge sys_clk) disable iff (sys_rst)
        quiet && !busy_reg && instr_valid && instr[11:9] == 3'b010
        && instr[4:0] == crc_pkg::PORT_B_ADDR && port_reg.dir_in[0] && instr[7:5] != 3'h0
        |=> port_reg.out_latch[0] == $past(pin_s2_reg[0]))
        else $error("input bit not refreshed");

    c_call: cover property (@(posedge sys_clk) busy_reg);
    c_kick: cover property (@(posedge sys_clk) wdc_reg);
    c_wake: cover property (@(posedge sys_clk) cause == crc_pkg::RST_CLEAR_WAKE);
    c_rmw: cover property (@(posedge sys_clk) $changed(port_reg.out_latch));
endmodule

// ### crc_pin_model.sv
// Model of the port pins with outside drivers on the input-configured bits.
`timescale 1ns/1ps
module crc_pin_model (
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe_n,
    input wire logic [7:0] ext_level,
    output logic [7:0] port_b_in
);
    // Released bits show the outside level, driven bits show the latch.
    assign port_b_in = (port_b_oe_n & ext_level) | (~port_b_oe_n & port_b_out);
endmodule

// ### tb_crc_core.sv
// Self-checking bench for reset causes, call, clear and port operations.
`timescale 1ns/1ps
module tb_crc_core;
    logic sys_clk, sys_rst, power_on, master_clear_n, watchdog_timeout, sleeping;
    logic instr_valid, prescaler_to_watchdog, watchdog_clear, prescaler_clear;
    logic instr_busy, file_wr_en;
    logic [11:0] instr;
    logic [7:0] port_b_in, port_dir_in, port_b_out, port_b_oe_n, status, working;
    logic [7:0] ext_level, latch_exp, k;
    logic [10:0] program_counter, stack_top, ret_exp;
    logic [1:0] flag_exp;
    logic [4:0] file_wr_addr;
    logic [31:0] rng;
    int errors, compares;
    int src_q[6] = '{2, 1, 2, 1, 0, 1};
    bit slp_q[6] = '{0, 0, 1, 1, 0, 0};

    crc_core i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .power_on(power_on),
        .master_clear_n(master_clear_n), .watchdog_timeout(watchdog_timeout),
        .sleeping(sleeping), .instr(instr), .instr_valid(instr_valid),
        .prescaler_to_watchdog(prescaler_to_watchdog), .port_b_in(port_b_in),
        .port_dir_in(port_dir_in), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
        .status(status), .working(working), .program_counter(program_counter),
        .stack_top(stack_top), .watchdog_clear(watchdog_clear),
        .prescaler_clear(prescaler_clear), .instr_busy(instr_busy),
        .file_wr_addr(file_wr_addr), .file_wr_en(file_wr_en));
    crc_pin_model i_pins (.port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
        .ext_level(ext_level), .port_b_in(port_b_in));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Time-out and power-down flags expected after a reset of the given source.
    function automatic logic [1:0] flags_after(input int which, input bit slp,
        input logic [1:0] prev);
        if (which == 0) return 2'b11;
        if (which == 1) return slp ? 2'b10 : prev;
        return slp ? 2'b00 : 2'b01;
    endfunction

    task automatic tally_and_finish();
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp_vec(input logic [10:0] got, input logic [10:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic exec(input logic [11:0] w);
        cyc(1);
        instr = w;
        instr_valid = 1'b1;
        cyc(1);
        instr_valid = 1'b0;
    endtask

    task automatic reset_source(input int which, input bit slp);
        sleeping = slp;
        cyc(1);
        if (which == 0) power_on = 1'b1;
        else if (which == 1) master_clear_n = 1'b0;
        else watchdog_timeout = 1'b1;
        cyc(2);
        power_on = 1'b0;
        master_clear_n = 1'b1;
        watchdog_timeout = 1'b0;
        cyc(6);
        sleeping = 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        {sys_rst, power_on, master_clear_n, watchdog_timeout, sleeping} = 5'b10100;
        {instr_valid, prescaler_to_watchdog, instr} = 14'h0000;
        port_dir_in = 8'hFF;
        ext_level = 8'h00;
        rng = 32'h00000022;
        flag_exp = 2'b11;
        cyc(8);
        sys_rst = 1'b0;
        cmp_vec(status[7:3], 5'b00011, "power-on status");
        cmp_vec(program_counter, crc_pkg::RESET_VECTOR, "reset vector");
        for (int i = 0; i < 6; i++) begin
            reset_source(src_q[i], slp_q[i]);
            flag_exp = flags_after(src_q[i], slp_q[i], flag_exp);
            cmp_vec(status[7:3], {3'b000, flag_exp}, "reset cause flags");
            cmp_vec(program_counter, crc_pkg::RESET_VECTOR, "full reset");
        end
        for (int p = 0; p < 2; p++) begin
            reset_source(2, 1'b1);
            prescaler_to_watchdog = p[0];
            exec(crc_pkg::WATCHDOG_KICK_OP);
            cmp_vec(status[4:3], 2'b11, "kick flags");
            cmp_flag(watchdog_clear, 1'b1, "watchdog cleared");
            cmp_flag(prescaler_clear, p[0], "prescaler cleared");
            cyc(1);
            cmp_flag(watchdog_clear, 1'b0, "watchdog pulse");
        end
        exec(crc_pkg::ZERO_WORKING_OP);
        cmp_vec(working, 8'h00, "working zero");
        cmp_flag(status[crc_pkg::Z_BIT], 1'b1, "zero flag");
        reset_source(0, 1'b0);
        cmp_flag(status[crc_pkg::Z_BIT], 1'b0, "zero flag after power-on");
        for (int f = 0; f < 32; f++) begin
            exec({crc_pkg::ZERO_FILE_OP, f[4:0]});
            cmp_flag(file_wr_en, 1'b1, "file write");
            cmp_vec(file_wr_addr, f[4:0], "file address");
            cmp_flag(status[crc_pkg::Z_BIT], 1'b1, "file zero flag");
        end
        ret_exp = program_counter + 11'h001;
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            k = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rng[7:0];
            exec({crc_pkg::CALL_OP, k});
            cmp_vec(program_counter, {3'b000, k}, "call target");
            cmp_vec(stack_top, ret_exp, "pushed return");
            cmp_flag(instr_busy, 1'b1, "call second cycle");
            cyc(1);
            cmp_flag(instr_busy, 1'b0, "call done");
            ret_exp = {3'b000, k} + 11'h001;
        end
        cyc(1);
        instr = {crc_pkg::CALL_OP, 8'h5A};
        instr_valid = 1'b1;
        cyc(1);
        instr = crc_pkg::WATCHDOG_KICK_OP;
        cyc(1);
        instr_valid = 1'b0;
        cmp_flag(watchdog_clear, 1'b0, "instruction during call ignored");
        cmp_vec(program_counter, 11'h05A, "call target held");
        latch_exp = 8'h00;
        for (int i = 0; i < 14; i++) begin
            rng = xs(rng);
            port_dir_in = (i == 0) ? 8'hFF : (i == 1) ? 8'hF0 : rng[7:0];
            ext_level = (i == 1) ? 8'hC0 : rng[15:8];
            cyc(4);
            latch_exp = (latch_exp & ~port_dir_in) | (ext_level & port_dir_in);
            latch_exp[rng[19:17]] = rng[16];
            exec({rng[16] ? crc_pkg::BIT_ONE_OP : crc_pkg::BIT_ZERO_OP, rng[19:17],
                crc_pkg::PORT_B_ADDR});
            cmp_vec(port_b_out, latch_exp, "port latch");
            cmp_vec(port_b_oe_n, port_dir_in, "port direction");
        end
        tally_and_finish();
    end
endmodule
